// >>> pkg/ctp_pkg.sv
// constants shared by the cascaded 8-bit timer pair block
// assumes a single system clock; all control bits arrive as plain ports
//
// Functional notes
// R1: upper select 100 forms one 16-bit counter
// R2: channels 2/3 cascade exactly like 0/1
// R3: lower select 100 counts upper match A
// R4: match count mode keeps channels independent
// R5: both cascade modes together stop both counters
// R6: 16-bit match flags upper, low byte lower
// R7: pins follow own selects on their matches
// R8: 16-bit capture sets both B flags, stores count
// R9: upper edge select chooses lower pin edge
// R10: upper clear select clears both counters
// R11: lower clear select ignored in 16-bit mode
// R12: upper wrap flag on 16-bit wrap
// R13: lower wrap flag on low byte wrap
// R14: selected pin edge copies counter into B
// R15: software enables capture, picks edge, then clock
// R16: capture in lower disables upper B compare
// R17: three gated request lines per channel
// R18: priority match A, then B, then wrap
// R19: lower A/B share, pair wraps share vector
// R20: converter request only from channel 0 match A
// R21: converter starts only if its enable set
// R22: trigger enable blocks external converter pin
// R23: upper byte steps when low byte wraps
package ctp_pkg;
  localparam logic [2:0]  CKS_DIV8     = 3'h1;
  localparam logic [2:0]  CKS_DIV64    = 3'h2;
  localparam logic [2:0]  CKS_DIV8192  = 3'h3;
  localparam logic [2:0]  CKS_CASCADE  = 3'h4;
  localparam logic [2:0]  CKS_EXT_RISE = 3'h5;
  localparam logic [2:0]  CKS_EXT_FALL = 3'h6;
  localparam logic [2:0]  CKS_EXT_BOTH = 3'h7;
  localparam logic [1:0]  CCLR_MATCH_A = 2'h1;
  localparam logic [1:0]  CCLR_MATCH_B = 2'h2;
  localparam logic [1:0]  CCLR_CAPTURE = 2'h3;
  localparam logic [1:0]  OUT_ZERO     = 2'h1;
  localparam logic [1:0]  OUT_ONE      = 2'h2;
  localparam logic [1:0]  OUT_TOGGLE   = 2'h3;
  localparam logic [1:0]  EDGE_RISE    = 2'h0;
  localparam logic [1:0]  EDGE_FALL    = 2'h1;
  localparam logic [1:0]  IRQ_NONE     = 2'h0;
  localparam logic [1:0]  IRQ_MATCH_A  = 2'h1;
  localparam logic [1:0]  IRQ_MATCH_B  = 2'h2;
  localparam logic [1:0]  IRQ_WRAP     = 2'h3;
  localparam int          PRE_W        = 13;
  localparam logic [12:0] PRE_MASK8    = 13'h0007;
  localparam logic [12:0] PRE_MASK64   = 13'h003F;
  localparam logic [12:0] PRE_MASK8192 = 13'h1FFF;
  localparam logic [12:0] PRE_RST      = 13'h0000;
  localparam logic [7:0]  CNT_MAX      = 8'hFF;
  localparam logic [7:0]  CNT_RST      = 8'h00;
  localparam logic [7:0]  CONST_B_RST  = 8'hFF;
  localparam logic [15:0] CNT16_MAX    = 16'hFFFF;
  localparam int          SYNC_W       = 7;
endpackage

// >>> rtl/ctp_chan.sv
// one 8-bit timer channel: counter, B register, flags and output pin
// assumes count, clear, match and capture events are formed by the pair logic
`timescale 1ns/1ns
module ctp_chan (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       inc_in,
  input  wire logic       clr_in,
  input  wire logic       ev_a_in,
  input  wire logic       ev_b_in,
  input  wire logic       cap_in,
  input  wire logic [7:0] cap_val_in,
  input  wire logic       b_wr_in,
  input  wire logic [7:0] b_wdata_in,
  input  wire logic [1:0] a_sel_in,
  input  wire logic [1:0] b_sel_in,
  input  wire logic       clr_fa_in,
  input  wire logic       clr_fb_in,
  input  wire logic       clr_fw_in,
  output logic      [7:0] cnt_out,
  output logic      [7:0] b_out,
  output logic            fa_out,
  output logic            fb_out,
  output logic            fw_out,
  output logic            pin_out
);
  logic [7:0] cnt_q, cnt_d, b_q, b_d;
  logic       fa_q, fb_q, fw_q, pin_q, pin_d, wrap;
  logic [1:0] act_a, act_b, act;

  assign wrap  = inc_in & (cnt_q == ctp_pkg::CNT_MAX) & ~clr_in;          // [R13]
  // clear beats increment; capture already took the pre-clear value
  assign cnt_d = clr_in ? ctp_pkg::CNT_RST : (inc_in ? cnt_q + 8'h01 : cnt_q);
  // a capture beats a software write of the same register
  assign b_d   = cap_in ? cap_val_in : (b_wr_in ? b_wdata_in : b_q);       // [R14]
  assign act_a = ev_a_in ? a_sel_in : 2'h0;
  assign act_b = ev_b_in ? b_sel_in : 2'h0;
  // action codes are ordered by priority: toggle > one > zero > none
  assign act   = (act_a > act_b) ? act_a : act_b;                          // [R7]
  assign pin_d = (act == ctp_pkg::OUT_TOGGLE) ? ~pin_q :
                 (act == ctp_pkg::OUT_ONE) ? 1'b1 :
                 (act == ctp_pkg::OUT_ZERO) ? 1'b0 : pin_q;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cnt_q <= ctp_pkg::CNT_RST;
      b_q   <= ctp_pkg::CONST_B_RST;
      fa_q  <= 1'b0;
      fb_q  <= 1'b0;
      fw_q  <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      b_q   <= b_d;
      fa_q  <= ev_a_in | (fa_q & ~clr_fa_in);
      fb_q  <= ev_b_in | cap_in | (fb_q & ~clr_fb_in);
      fw_q  <= wrap | (fw_q & ~clr_fw_in);
      pin_q <= pin_d;
    end
  end

  assign cnt_out = cnt_q;
  assign b_out   = b_q;
  assign fa_out  = fa_q;
  assign fb_out  = fb_q;
  assign fw_out  = fw_q;
  assign pin_out = pin_q;
endmodule // ctp_chan

// >>> rtl/ctp_top.sv
// two cascadable pairs of 8-bit timers (0 upper/1 lower, 2 upper/3 lower)
// assumes control fields arrive as static software-set levels on plain ports
`timescale 1ns/1ns
module ctp_top (
  input  wire logic        CLK_IN,
  input  wire logic        NRST_IN,
  input  wire logic [11:0] CLK_SEL_IN,
  input  wire logic [7:0]  CLEAR_SEL_IN,
  input  wire logic [7:0]  OUT_A_SEL_IN,
  input  wire logic [7:0]  OUT_B_SEL_IN,
  input  wire logic [1:0]  CAPTURE_ENABLE_IN,
  input  wire logic [3:0]  IRQ_EN_A_IN,
  input  wire logic [3:0]  IRQ_EN_B_IN,
  input  wire logic [3:0]  IRQ_EN_W_IN,
  input  wire logic        ADC_TRIG_ENABLE_IN,
  input  wire logic [31:0] CONST_A_IN,
  input  wire logic [31:0] CONST_B_WDATA_IN,
  input  wire logic [3:0]  CONST_B_WR_IN,
  input  wire logic [3:0]  FLAG_A_CLR_IN,
  input  wire logic [3:0]  FLAG_B_CLR_IN,
  input  wire logic [3:0]  FLAG_W_CLR_IN,
  input  wire logic [3:0]  EXT_CLK_IN,
  input  wire logic [1:0]  TIMER_IO_PIN_IN,
  input  wire logic        ADC_TRIGGER_PIN_IN,
  output logic      [31:0] COUNTER_OUT,
  output logic      [31:0] CONST_B_OUT,
  output logic      [3:0]  MATCH_A_FLAG_OUT,
  output logic      [3:0]  MATCH_B_FLAG_OUT,
  output logic      [3:0]  WRAP_FLAG_OUT,
  output logic      [3:0]  TIMER_OUT_PIN_OUT,
  output logic      [1:0]  TIMER_IO_OE_OUT,
  output logic      [3:0]  MATCH_A_IRQ_OUT,
  output logic      [3:0]  MATCH_B_IRQ_OUT,
  output logic      [3:0]  WRAP_IRQ_OUT,
  output logic      [1:0]  SHARED_MATCH_IRQ_OUT,
  output logic      [1:0]  SHARED_WRAP_IRQ_OUT,
  output logic      [7:0]  IRQ_TOP_SRC_OUT,
  output logic             ADC_REQ_OUT,
  output logic             ADC_EXT_TRIG_OUT
);
  // pin synchroniser: bits 3..0 ext clocks, 5..4 io pins, 6 converter pin
  logic [ctp_pkg::SYNC_W-1:0] s1_q, s2_q, s3_q, pins;
  logic [ctp_pkg::PRE_W-1:0]  pre_q;
  logic                       pre_t8, pre_t64, pre_t8192;
  logic [7:0]                 cnt [4];
  logic [7:0]                 breg [4];
  logic [7:0]                 cva [4];
  logic                       base [4];
  logic                       tick [4];
  logic                       clr [4];
  logic                       ma [4];
  logic                       mb [4];
  logic                       cap [4];
  logic                       fa [4];
  logic                       fb [4];
  logic                       fw [4];
  logic [3:0]                 ia_q, ib_q, iw_q;
  logic [1:0]                 sm_q, sw_q, oe_q;
  logic [7:0]                 src_q;
  logic                       adc_req_q, adc_ext_q, adc_req_d;

  assign pins = {ADC_TRIGGER_PIN_IN, TIMER_IO_PIN_IN, EXT_CLK_IN};

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      pre_q <= ctp_pkg::PRE_RST;
    end else begin
      s1_q  <= pins;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pre_q <= pre_q + 13'h0001;
    end
  end

  assign pre_t8    = (pre_q & ctp_pkg::PRE_MASK8) == ctp_pkg::PRE_MASK8;
  assign pre_t64   = (pre_q & ctp_pkg::PRE_MASK64) == ctp_pkg::PRE_MASK64;
  assign pre_t8192 = (pre_q & ctp_pkg::PRE_MASK8192) == ctp_pkg::PRE_MASK8192;

  // per-channel clock source and the channel itself
  for (genvar c = 0; c < 4; c++) begin : g_ch
    logic [2:0] sel;
    logic       rise, fall;
    assign sel  = CLK_SEL_IN[3*c +: 3];
    assign rise = s2_q[c] & ~s3_q[c];
    assign fall = ~s2_q[c] & s3_q[c];
    assign cva[c]  = CONST_A_IN[8*c +: 8];
    assign base[c] = ((sel == ctp_pkg::CKS_DIV8) & pre_t8) |
                     ((sel == ctp_pkg::CKS_DIV64) & pre_t64) |
                     ((sel == ctp_pkg::CKS_DIV8192) & pre_t8192) |
                     ((sel == ctp_pkg::CKS_EXT_RISE) & rise) |
                     ((sel == ctp_pkg::CKS_EXT_FALL) & fall) |
                     ((sel == ctp_pkg::CKS_EXT_BOTH) & (rise | fall));

    ctp_chan u_chan (
      .clk_in     (CLK_IN),
      .nrst_in    (NRST_IN),
      .inc_in     (tick[c]),
      .clr_in     (clr[c]),
      .ev_a_in    (ma[c]),
      .ev_b_in    (mb[c]),
      .cap_in     (cap[c]),
      .cap_val_in (cnt[c]),
      .b_wr_in    (CONST_B_WR_IN[c]),
      .b_wdata_in (CONST_B_WDATA_IN[8*c +: 8]),
      .a_sel_in   (OUT_A_SEL_IN[2*c +: 2]),
      .b_sel_in   (OUT_B_SEL_IN[2*c +: 2]),
      .clr_fa_in  (FLAG_A_CLR_IN[c]),
      .clr_fb_in  (FLAG_B_CLR_IN[c]),
      .clr_fw_in  (FLAG_W_CLR_IN[c]),
      .cnt_out    (cnt[c]),
      .b_out      (breg[c]),
      .fa_out     (fa[c]),
      .fb_out     (fb[c]),
      .fw_out     (fw[c]),
      .pin_out    (TIMER_OUT_PIN_OUT[c])
    );

    assign COUNTER_OUT[8*c +: 8] = cnt[c];
    assign CONST_B_OUT[8*c +: 8] = breg[c];
    assign MATCH_A_FLAG_OUT[c]   = fa[c];
    assign MATCH_B_FLAG_OUT[c]   = fb[c];
    assign WRAP_FLAG_OUT[c]      = fw[c];

    always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
        ia_q[c]        <= 1'b0;
        ib_q[c]        <= 1'b0;
        iw_q[c]        <= 1'b0;
        src_q[2*c +: 2] <= ctp_pkg::IRQ_NONE;
      end else begin
        ia_q[c] <= fa[c] & IRQ_EN_A_IN[c];                                 // [R17]
        ib_q[c] <= fb[c] & IRQ_EN_B_IN[c];                                 // [R17]
        iw_q[c] <= fw[c] & IRQ_EN_W_IN[c];                                 // [R17]
        src_q[2*c +: 2] <= (fa[c] & IRQ_EN_A_IN[c]) ? ctp_pkg::IRQ_MATCH_A :   // [R18]
                           (fb[c] & IRQ_EN_B_IN[c]) ? ctp_pkg::IRQ_MATCH_B :
                           (fw[c] & IRQ_EN_W_IN[c]) ? ctp_pkg::IRQ_WRAP :
                           ctp_pkg::IRQ_NONE;
      end
    end
  end

  // cascade logic, identical for both pairs
  for (genvar p = 0; p < 2; p++) begin : g_pair   // [R2]
    localparam int U = 2 * p;
    localparam int L = 2 * p + 1;
    logic       mode16, cmc, bad, capture_enable, edge_hit;
    logic       eq_a_u, eq_b_u, cev_u, cev_l;
    logic [1:0] esel;
    logic [1:0] csel_u, csel_l;
    logic       prise, pfall;

    assign mode16 = CLK_SEL_IN[3*U +: 3] == ctp_pkg::CKS_CASCADE;          // [R1]
    assign cmc    = CLK_SEL_IN[3*L +: 3] == ctp_pkg::CKS_CASCADE;          // [R3]
    assign bad    = mode16 & cmc;
    assign capture_enable    = CAPTURE_ENABLE_IN[p];
    assign csel_u = CLEAR_SEL_IN[2*U +: 2];
    assign csel_l = CLEAR_SEL_IN[2*L +: 2];

    // the lower counter's match A input is built from the upper's base clock so
    // that no combinational loop runs through the two cascade selects
    assign tick[L] = ~bad & (cmc ? (base[U] & (cnt[U] == cva[U])) : base[L]);   // [R3] [R5]
    assign tick[U] = ~bad & (mode16 ? (base[L] & (cnt[L] == ctp_pkg::CNT_MAX))  // [R23] [R5]
                                    : base[U]);

    assign eq_a_u = mode16 ? ({cnt[U], cnt[L]} == {cva[U], cva[L]}) : (cnt[U] == cva[U]);
    assign eq_b_u = mode16 ? ({cnt[U], cnt[L]} == {breg[U], breg[L]}) : (cnt[U] == breg[U]);
    assign ma[U]  = (mode16 ? tick[L] : tick[U]) & eq_a_u;                 // [R6] [R4]
    assign ma[L]  = tick[L] & (cnt[L] == cva[L]);                          // [R6] [R4]
    assign mb[U]  = ~capture_enable & (mode16 ? tick[L] : tick[U]) & eq_b_u;          // [R16]
    assign mb[L]  = ~capture_enable & tick[L] & (cnt[L] == breg[L]);

    // edge select comes from the upper channel while cascaded
    assign esel     = mode16 ? OUT_B_SEL_IN[2*U +: 2] : OUT_B_SEL_IN[2*L +: 2];   // [R9]
    assign prise    = s2_q[4+p] & ~s3_q[4+p];
    assign pfall    = ~s2_q[4+p] & s3_q[4+p];
    assign edge_hit = (esel == ctp_pkg::EDGE_RISE) ? prise :
                      (esel == ctp_pkg::EDGE_FALL) ? pfall : (prise | pfall);
    assign cap[L]   = capture_enable & edge_hit;                                      // [R14]
    assign cap[U]   = mode16 & cap[L];                                     // [R8]

    assign cev_u = ((csel_u == ctp_pkg::CCLR_MATCH_A) & ma[U]) |
                   ((csel_u == ctp_pkg::CCLR_MATCH_B) & mb[U]) |
                   ((csel_u == ctp_pkg::CCLR_CAPTURE) & cap[U]);
    assign cev_l = ((csel_l == ctp_pkg::CCLR_MATCH_A) & ma[L]) |
                   ((csel_l == ctp_pkg::CCLR_MATCH_B) & mb[L]) |
                   ((csel_l == ctp_pkg::CCLR_CAPTURE) & cap[L]);
    assign clr[U] = cev_u;                                                 // [R10]
    assign clr[L] = mode16 ? cev_u : cev_l;                                // [R10] [R11]

    always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
        sm_q[p] <= 1'b0;
        sw_q[p] <= 1'b0;
        oe_q[p] <= 1'b0;
      end else begin
        sm_q[p] <= (fa[L] & IRQ_EN_A_IN[L]) | (fb[L] & IRQ_EN_B_IN[L]);    // [R19]
        sw_q[p] <= (fw[U] & IRQ_EN_W_IN[U]) | (fw[L] & IRQ_EN_W_IN[L]);    // [R19]
        oe_q[p] <= ~capture_enable & ((OUT_A_SEL_IN[2*L +: 2] | OUT_B_SEL_IN[2*L +: 2]) != 2'h0);
      end
    end

    sequence s_cap16;
      mode16 && cap[L];
    endsequence
    sequence s_both_b_set;
      fb[U] && fb[L];
    endsequence

    AST_CARRY: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)   // [R23]
      (mode16 && tick[L] && cnt[L] == ctp_pkg::CNT_MAX && !clr[U])
      |=> (cnt[U] == $past(cnt[U]) + 8'h01) && (cnt[L] == ctp_pkg::CNT_RST))
      else $error("upper byte did not carry on low byte wrap");
    AST_BAD_MODE: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)   // [R5]
      (bad && !clr[U] && !clr[L]) |=> ($stable(cnt[U]) && $stable(cnt[L])))
      else $error("counter moved with both cascade modes set");
    AST_CMC_COUNT: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)   // [R3]
      (cmc && !mode16 && base[U] && cnt[U] == cva[U] && !clr[L])
      |=> cnt[L] == $past(cnt[L]) + 8'h01)
      else $error("lower counter missed an upper match A");
    AST_FLAG16: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)   // [R6]
      (mode16 && tick[L] && {cnt[U], cnt[L]} == {cva[U], cva[L]}) |=> fa[U])
      else $error("16-bit match did not set upper flag");
    AST_WRAP16: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)   // [R12]
      (mode16 && tick[L] && {cnt[U], cnt[L]} == ctp_pkg::CNT16_MAX && !clr[U])
      |=> fw[U] && fw[L])
      else $error("16-bit wrap did not set wrap flags");
    AST_CAPTURE16: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)   // [R8]
      s_cap16 |=> s_both_b_set ##0 ({breg[U], breg[L]} == $past({cnt[U], cnt[L]})))
      else $error("16-bit capture incomplete");
    AST_NO_B_CMP: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)   // [R16]
      (capture_enable && !cap[U] && !fb[U] && !FLAG_B_CLR_IN[U]) |=> !fb[U])
      else $error("upper B compared while lower captures");
  end

  assign adc_req_d = ma[0] & ADC_TRIG_ENABLE_IN;                           // [R20]

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      adc_req_q <= 1'b0;
      adc_ext_q <= 1'b0;
    end else begin
      adc_req_q <= adc_req_d;
      adc_ext_q <= s2_q[6] & ~ADC_TRIG_ENABLE_IN;                          // [R22]
    end
  end

  AST_ADC_REQ: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)   // [R20]
    ADC_REQ_OUT == $past(ma[0] && ADC_TRIG_ENABLE_IN))
    else $error("converter request not tied to channel 0 match A");
  AST_EXT_BLOCK: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)   // [R22]
    ADC_TRIG_ENABLE_IN ##1 ADC_TRIG_ENABLE_IN |-> !ADC_EXT_TRIG_OUT)
    else $error("external converter trigger passed while blocked");

  assign MATCH_A_IRQ_OUT      = ia_q;
  assign MATCH_B_IRQ_OUT      = ib_q;
  assign WRAP_IRQ_OUT         = iw_q;
  assign SHARED_MATCH_IRQ_OUT = sm_q;
  assign SHARED_WRAP_IRQ_OUT  = sw_q;
  assign IRQ_TOP_SRC_OUT      = src_q;
  assign TIMER_IO_OE_OUT      = oe_q;
  assign ADC_REQ_OUT          = adc_req_q;
  assign ADC_EXT_TRIG_OUT     = adc_ext_q;
endmodule // ctp_top

// >>> verification/ctp_adc_model.sv
// converter model standing on the timer's conversion request line
// assumes the request is a registered one-clock pulse on the system clock
`timescale 1ns/1ns
module ctp_adc_model (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       req_in,
  input  wire logic       trig_en_in,
  output logic      [7:0] conv_cnt_out
);
  // a request seen while the converter's own trigger enable is low is dropped
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      conv_cnt_out <= 8'h00;
    end else if (req_in && trig_en_in) begin
      conv_cnt_out <= conv_cnt_out + 8'h01;
    end
  end
endmodule // ctp_adc_model

// >>> verification/tb_ctp_top.sv
// self-checking bench for the cascaded timer pair block
// assumes the converter model watches the request output; inputs move at falling edges
`timescale 1ns/1ns
module tb_ctp_top;
  logic        clk, nrst, adc_trig_enable, adpin, adreq, adext;
  logic [11:0] csel;
  logic [7:0]  clrs, osa, osb, top, conv;
  logic [1:0]  cen, tio, oe, sm, sw;
  logic [3:0]  iea, ieb, iew, cbwr, fca, fcb, fcw, ext, fa, fb, fw, pin, ia, ib, iw;
  logic [31:0] cona, cbw, cnt, cb;
  int          bad_count, checks_done;

  ctp_top dut (
    .CLK_IN(clk), .NRST_IN(nrst), .CLK_SEL_IN(csel), .CLEAR_SEL_IN(clrs),
    .OUT_A_SEL_IN(osa), .OUT_B_SEL_IN(osb), .CAPTURE_ENABLE_IN(cen), .IRQ_EN_A_IN(iea),
    .IRQ_EN_B_IN(ieb), .IRQ_EN_W_IN(iew), .ADC_TRIG_ENABLE_IN(adc_trig_enable), .CONST_A_IN(cona),
    .CONST_B_WDATA_IN(cbw), .CONST_B_WR_IN(cbwr), .FLAG_A_CLR_IN(fca), .FLAG_B_CLR_IN(fcb),
    .FLAG_W_CLR_IN(fcw), .EXT_CLK_IN(ext), .TIMER_IO_PIN_IN(tio),
    .ADC_TRIGGER_PIN_IN(adpin), .COUNTER_OUT(cnt), .CONST_B_OUT(cb), .MATCH_A_FLAG_OUT(fa),
    .MATCH_B_FLAG_OUT(fb), .WRAP_FLAG_OUT(fw), .TIMER_OUT_PIN_OUT(pin), .TIMER_IO_OE_OUT(oe),
    .MATCH_A_IRQ_OUT(ia), .MATCH_B_IRQ_OUT(ib), .WRAP_IRQ_OUT(iw),
    .SHARED_MATCH_IRQ_OUT(sm), .SHARED_WRAP_IRQ_OUT(sw), .IRQ_TOP_SRC_OUT(top),
    .ADC_REQ_OUT(adreq), .ADC_EXT_TRIG_OUT(adext)
  );

  ctp_adc_model adc (
    .clk_in(clk), .nrst_in(nrst), .req_in(adreq), .trig_en_in(1'b1), .conv_cnt_out(conv)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // every input back to idle; constants A parked at FF so stray matches stay rare
  task automatic restart();
    nrst = 1'b0;
    {adc_trig_enable, adpin, csel, clrs, osa, osb, cen, tio} = '0;
    {iea, ieb, iew, cbwr, fca, fcb, fcw, ext} = '0;
    cbw = '0;
    cona = 32'hFFFF_FFFF;
    cyc(2);
    nrst = 1'b1;
  endtask

  // each high and low phase spans four clocks, well past the two-stage synchroniser
  task automatic pulse(input logic [3:0] m, input int n);
    repeat (n) begin
      ext = m;
      cyc(4);
      ext = 4'h0;
      cyc(4);
    end
  endtask

  task automatic scen_cascade(input int p);
    restart();
    check("counter reset", cnt, 32'h0000_0000);
    check("const b reset", cb, 32'hFFFF_FFFF);
    csel[6*p +: 3] = 3'h4;
    csel[6*p+3 +: 3] = 3'h5;
    cona[16*p +: 16] = 16'h0201;
    iea = 4'hF;
    iew = 4'hF;
    pulse(p ? 4'h8 : 4'h2, 258);
    check("count16", {cnt[16*p +: 8], cnt[16*p+8 +: 8]}, 32'h0000_0102);
    check("wrap flags", fw[2*p +: 2], 32'h0000_0002);
    check("wrap irq shared", sw[p], 32'h0000_0001);
    check("match a low only", fa[2*p +: 2], 32'h0000_0002);
    pulse(p ? 4'h8 : 4'h2, 1);
    check("match a both", fa[2*p +: 2], 32'h0000_0003);
    check("match a irq", ia[2*p +: 2], 32'h0000_0003);
    check("count after", {cnt[16*p +: 8], cnt[16*p+8 +: 8]}, 32'h0000_0103);
    $display("test cascade pair %0d finished", p);
  endtask

  task automatic scen_clear();
    restart();
    cbw[15:8] = 8'h03;
    cbwr = 4'h2;
    cyc(1);
    cbwr = 4'h0;
    check("const b write", cb[15:8], 32'h0000_0003);
    csel[5:0] = 6'h2C;
    clrs[3:0] = 4'h9;
    cona[15:0] = 16'h0600;
    osa[1:0] = ctp_pkg::OUT_TOGGLE;
    osb[3:2] = ctp_pkg::OUT_ONE;
    pulse(4'h2, 5);
    check("low byte kept", cnt[15:0], 32'h0000_0500);
    check("pins low match", pin[1:0], 32'h0000_0002);
    pulse(4'h2, 2);
    check("both cleared", cnt[15:0], 32'h0000_0000);
    check("pins full match", pin[1:0], 32'h0000_0003);
    $display("test clear finished");
  endtask

  task automatic scen_mcount();
    restart();
    csel[5:0] = 6'h25;
    clrs[1:0] = ctp_pkg::CCLR_MATCH_A;
    cona[15:0] = 16'hFF02;
    pulse(4'h1, 9);
    check("match count", cnt[15:0], 32'h0000_0300);
    check("own flags", fa[1:0], 32'h0000_0001);
    csel[2:0] = 3'h4;
    pulse(4'h3, 3);
    check("both modes stall", cnt[15:0], 32'h0000_0300);
    $display("test match count finished");
  endtask

  task automatic scen_capture();
    restart();
    cen[0] = 1'b1;
    cyc(1);
    osb[3:0] = 4'h1;
    cyc(1);
    csel[5:0] = 6'h2C;
    pulse(4'h2, 5);
    tio[0] = 1'b1;
    cyc(6);
    check("rise ignored", fb[1:0], 32'h0000_0000);
    tio[0] = 1'b0;
    cyc(6);
    check("capture flags", fb[1:0], 32'h0000_0003);
    check("capture value", cb[15:0], 32'h0000_0500);
    check("io pin released", oe[0], 32'h0000_0000);
    fcb = 4'h3;
    cyc(1);
    fcb = 4'h0;
    pulse(4'h2, 1);
    check("upper b no compare", fb[0], 32'h0000_0000);
    $display("test capture finished");
  endtask

  task automatic scen_irq();
    restart();
    cbw[7:0] = 8'h01;
    cbwr = 4'h1;
    cyc(1);
    cbwr = 4'h0;
    csel[5:0] = 6'h2D;
    cona[15:0] = 16'h0101;
    iea = 4'h3;
    ieb = 4'h3;
    adc_trig_enable = 1'b1;
    adpin = 1'b1;
    pulse(4'h3, 2);
    check("top source a", top[1:0], ctp_pkg::IRQ_MATCH_A);
    check("a irq", ia[1:0], 32'h0000_0003);
    check("b irq", ib[0], 32'h0000_0001);
    check("shared match", sm[0], 32'h0000_0001);
    check("conversions", conv, 32'h0000_0001);
    check("ext trig blocked", adext, 32'h0000_0000);
    fca = 4'h1;
    cyc(1);
    fca = 4'h0;
    cyc(2);
    check("top source b", top[1:0], ctp_pkg::IRQ_MATCH_B);
    check("a irq cleared", ia[0], 32'h0000_0000);
    iea[1] = 1'b0;
    cyc(2);
    check("shared masked", sm[0], 32'h0000_0000);
    adc_trig_enable = 1'b0;
    cyc(4);
    check("ext trig open", adext, 32'h0000_0001);
    $display("test interrupts finished");
  endtask

  initial begin
    bad_count = 0;
    checks_done = 0;
    scen_cascade(0);
    scen_cascade(1);
    scen_clear();
    scen_mcount();
    scen_capture();
    scen_irq();
    final_report();
  end

  // hang guard well above the few thousand cycles the scenarios need
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    final_report();
  end
endmodule // tb_ctp_top
